// File: pkg/dac_link_if.sv
// Three-wire serial link plus load strobe between controller and DAC
`timescale 1ns/10ps
interface dac_link_if;

  logic sync_n;         // Frame sync, active low
  logic sclk;           // Link clock, idles high
  logic din;            // Serial data, MSB first
  logic load_strobe_n;  // Load strobe, active low

  // Controller end drives every wire
  modport host_mp
  (
    output sync_n,
    output sclk,
    output din,
    output load_strobe_n
  );

  // DAC end only listens
  modport device_mp
  (
    input sync_n,
    input sclk,
    input din,
    input load_strobe_n
  );

endinterface

// File: pkg/dac_load_pkg.sv
// Shared constants for the octal DAC serial link and load-update logic
package dac_load_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;        // Bits per serial frame
  localparam int CH_COUNT = 8;          // Number of DAC channels
  localparam int CH_BITS = 3;           // Width of a channel address
  localparam int POS_CTRL = 15;         // 1 = control word, 0 = DAC write
  localparam int POS_ADDR = 12;         // Low bit of channel address
  localparam int POS_MODE = 13;         // Low bit of control mode
  localparam int POS_DATA_TOP = 11;     // Top bit of DAC data
  localparam int POS_FULL_RST = 12;     // Reset mode: also reset controls
  localparam int POS_GAIN = 4;          // Gain pair, quad E-H in upper bit
  localparam int POS_BUF = 2;           // Buffer pair
  localparam int POS_VDD = 0;           // Supply-reference pair
  localparam int POS_LDM = 0;           // Load-mode field

  // ----------------------------------------------------------------
  // Control modes and load-mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_REF_GAIN = 2'h0;
  localparam logic [1:0] MODE_LOAD = 2'h1;
  localparam logic [1:0] MODE_PWR_DOWN = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h3;
  localparam logic [1:0] LDM_LOW = 2'h0;      // Transparent
  localparam logic [1:0] LDM_HIGH = 2'h1;     // Latched
  localparam logic [1:0] LDM_SINGLE = 2'h2;   // One load pulse
  localparam logic [1:0] LDM_RSVD = 2'h3;     // Reserved, acts latched

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_LDM = LDM_HIGH;
  localparam logic [1:0] RST_PAIR = 2'h0;
  localparam logic [7:0] RST_PWR_DOWN = 8'h00;
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_BYTE_MODE = 1'b0;

  // ----------------------------------------------------------------
  // Controller register map (APB byte offsets)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam int CTRL_STROBE = 0;       // Level driven on load strobe
  localparam int CTRL_BYTE = 1;         // Send frame as two bytes

  // ----------------------------------------------------------------
  // Link timing at the core clock rate
  // ----------------------------------------------------------------
  localparam int CORE_MHZ = 100;
  localparam int SCLK_HALF_NS = 40;     // Least half period of link clock
  localparam int BYTE_PAUSE_NS = 200;   // Idle between the two bytes
  localparam int FRAME_GAP_NS = 100;    // Least sync-high time between frames
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CORE_MHZ + 999) / 1000;
  localparam int BYTE_PAUSE_CYC = (BYTE_PAUSE_NS * CORE_MHZ + 999) / 1000;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS * CORE_MHZ + 999) / 1000;

endpackage

// File: rtl/dac_load_device.sv
// DAC end: serial capture, input registers and load-update logic
//
// Function
// - Strobe pin and load mode gate loads.
// - Software control: host ties strobe high.
// - Strobe control: host keeps latched mode.
// - Gain, buffer, supply settings double-buffered.
// - Synchronous: load right after sixteenth edge.
// - Asynchronous: writes wait for strobe fall.
// - Full frame writes addressed input register.
// - Strobe high, mode 01: outputs latched.
// - Mode 00 or strobe low: transparent.
// - Host writes seven, strobes on eighth.
// - Only written channels reload on load.
// - Sample on falling edge, MSB first.
// - Byte host holds sync across bytes.
// - Host frames sixteen bits, changes rising.
// - Early sync rise aborts the frame.
// - Mode 10 one pulse; 11 reserved.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
module dac_load_device
  import dac_load_pkg::*;
#(
  parameter int DATA_W = 12
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  dac_link_if.device_mp LINK,
  output logic [CH_COUNT*DATA_W-1:0] DAC_CODE_OUT,
  output logic [1:0] GAIN_OUT,
  output logic [1:0] BUF_OUT,
  output logic [1:0] VDD_REF_OUT,
  output logic [CH_COUNT-1:0] POWER_DOWN_OUT,
  output logic [1:0] LOAD_MODE_OUT
);

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------

  // Frame progress, cleared whenever sync is high
  typedef struct packed {
    logic [4:0] cnt;    // Falling edges seen in this frame
    logic full;         // Sixteen edges reached
  } frame_s;

  // Shift path, kept across the sync-high gap
  typedef struct packed {
    logic [WORD_BITS-1:0] shift;  // Bits as they arrive
    logic [WORD_BITS-1:0] word;   // Last complete word
  } shift_s;

  frame_s frm_q; // Frame counter state
  frame_s frm_d; // Its next value
  shift_s shf_q; // Shift state
  shift_s shf_d; // Its next value

  // Count edges; the count stops at sixteen
  always_comb
  begin
    frm_d = frm_q;
    if (frm_q.cnt != 5'(WORD_BITS))
    begin
      frm_d.cnt = frm_q.cnt + 5'd1;
    end
    if (frm_q.cnt == 5'(WORD_BITS - 1))
    begin
      frm_d.full = 1'b1;
    end
  end

  always_ff @(negedge LINK.sclk or posedge LINK.sync_n)
  begin
    if (LINK.sync_n)
    begin
      frm_q <= '0;
    end
    else
    begin
      frm_q <= frm_d;
    end
  end

  // Shift in one bit; latch the word on the last one
  always_comb
  begin
    shf_d = shf_q;
    shf_d.shift = {shf_q.shift[WORD_BITS-2:0], LINK.din};
    if (frm_q.cnt == 5'(WORD_BITS - 1))
    begin
      shf_d.word = shf_d.shift;
    end
  end

  always_ff @(negedge LINK.sclk)
  begin
    shf_q <= shf_d;
  end

  // ----------------------------------------------------------------
  // Core clock domain
  // ----------------------------------------------------------------

  // Whole core state
  typedef struct packed {
    logic [2:0] str_sync;   // Strobe synchroniser chain
    logic str;              // Settled strobe level
    logic [2:0] full_sync;  // Frame-done synchroniser chain
    logic full;             // Settled frame-done level
    logic [CH_COUNT-1:0][DATA_W-1:0] in_code;  // Input registers
    logic [CH_COUNT-1:0][DATA_W-1:0] dac_code; // DAC registers
    logic [CH_COUNT-1:0] pend;  // Input written since last load
    logic [1:0] gain_in;        // Pending gain pair
    logic [1:0] buf_in;         // Pending buffer pair
    logic [1:0] vdd_in;         // Pending supply-reference pair
    logic set_pend;             // Pending settings not yet applied
    logic [1:0] gain;           // Active gain pair
    logic [1:0] bufr;           // Active buffer pair
    logic [1:0] vdd;            // Active supply-reference pair
    logic [CH_COUNT-1:0] pd;    // Powered-down channels
    logic [1:0] ldm;            // Load mode
    logic single;               // One-shot load request
  } core_s;

  core_s q; // Core state
  core_s d; // Its next value

  // Accept a synchronised level once the last two stages agree
  function automatic logic settle(input logic [2:0] chain, input logic old);
    settle = (chain[1] == chain[2]) ? chain[2] : old;
  endfunction

  logic commit; // Completed frame arrived this cycle
  logic load;   // Load condition active this cycle
  logic [WORD_BITS-1:0] w; // Word being committed
  logic [CH_BITS-1:0] ch;  // Addressed channel

  // Next-state logic of the core
  always_comb
  begin
    d = q;
    w = shf_q.word;
    ch = w[POS_ADDR +: CH_BITS];
    // Pin and link-done levels enter through three stages
    d.str_sync = {q.str_sync[1:0], LINK.load_strobe_n};
    d.full_sync = {q.full_sync[1:0], frm_q.full};
    d.str = settle(q.str_sync, q.str);
    d.full = settle(q.full_sync, q.full);
    commit = d.full & ~q.full;
    load = (q.ldm == LDM_LOW) | ~q.str | q.single;
    d.single = 1'b0;
    for (int i = 0; i < CH_COUNT; i++)
    begin
      if (load && q.pend[i])
      begin
        d.dac_code[i] = q.in_code[i];
        d.pend[i] = 1'b0;
      end
    end
    if (load && q.set_pend)
    begin
      d.gain = q.gain_in;
      d.bufr = q.buf_in;
      d.vdd = q.vdd_in;
      d.set_pend = 1'b0;
    end
    // Decode a committed word; a new write wins over a load
    if (commit)
    begin
      if (!w[POS_CTRL])
      begin
        d.in_code[ch] = w[POS_DATA_TOP -: DATA_W];
        d.pend[ch] = 1'b1;
      end
      else
      begin
        case (w[POS_MODE +: 2])
          MODE_REF_GAIN:
          begin
            d.gain_in = w[POS_GAIN +: 2];
            d.buf_in = w[POS_BUF +: 2];
            d.vdd_in = w[POS_VDD +: 2];
            d.set_pend = 1'b1;
          end
          MODE_LOAD:
          begin
            d.ldm = w[POS_LDM +: 2];
            d.single = (w[POS_LDM +: 2] == LDM_SINGLE);
          end
          MODE_PWR_DOWN:
          begin
            // Power-down takes effect at once
            d.pd = w[CH_COUNT-1:0];
          end
          default:
          begin
            // Data reset clears both banks
            d.in_code = '0;
            d.dac_code = '0;
            d.pend = '0;
            if (w[POS_FULL_RST])
            begin
              // Control reset restores power-on settings
              d.gain_in = RST_PAIR;
              d.buf_in = RST_PAIR;
              d.vdd_in = RST_PAIR;
              d.gain = RST_PAIR;
              d.bufr = RST_PAIR;
              d.vdd = RST_PAIR;
              d.set_pend = 1'b0;
              d.pd = RST_PWR_DOWN;
              d.ldm = RST_LDM;
              d.single = 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Core register, synchronous reset
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RESET_IN)
    begin
      q <= '0;
      q.str_sync <= {3{RST_STROBE_N}};
      q.str <= RST_STROBE_N;
      q.gain_in <= RST_PAIR;
      q.buf_in <= RST_PAIR;
      q.vdd_in <= RST_PAIR;
      q.gain <= RST_PAIR;
      q.bufr <= RST_PAIR;
      q.vdd <= RST_PAIR;
      q.pd <= RST_PWR_DOWN;
      q.ldm <= RST_LDM;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the core register
  // ----------------------------------------------------------------
  assign DAC_CODE_OUT = q.dac_code;
  assign GAIN_OUT = q.gain;
  assign BUF_OUT = q.bufr;
  assign VDD_REF_OUT = q.vdd;
  assign POWER_DOWN_OUT = q.pd;
  assign LOAD_MODE_OUT = q.ldm;

endmodule

// File: rtl/dac_load_host.sv
// Controller end: APB registers drive serial frames and load strobe
`timescale 1ns/10ps
module dac_load_host
  import dac_load_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  dac_link_if.host_mp LINK
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  // Frame sequencer states
  typedef enum logic [2:0] {
    H_IDLE,   // Sync high, waiting for a command
    H_LEAD,   // Sync low, before first falling edge
    H_LOW,    // Link clock low
    H_HIGH,   // Link clock high, next bit on data
    H_TAIL,   // After last rising edge, before sync rise
    H_GAP     // Sync high, least gap before next frame
  } hstate_e;

  // Whole controller state
  typedef struct packed {
    hstate_e st;             // Sequencer state
    logic [7:0] tmr;         // Cycles left in this phase
    logic [3:0] bits;        // Bits completed
    logic [WORD_BITS-1:0] sh; // Word being sent, MSB at top
    logic sync_n;            // Frame sync drive
    logic sclk;              // Link clock drive
    logic din;               // Data drive
    logic strobe_n;          // Load strobe drive
    logic byte_mode;         // Send as two bytes
    logic ready;             // APB answer
    logic slverr;            // APB error
    logic [31:0] rdata;      // APB read data
  } host_s;

  host_s q; // Controller state
  host_s d; // Its next value

  localparam logic [7:0] HALF_LD = 8'(SCLK_HALF_CYC - 1);
  localparam logic [7:0] PAUSE_LD = 8'(BYTE_PAUSE_CYC - 1);
  localparam logic [7:0] GAP_LD = 8'(FRAME_GAP_CYC - 1);

  logic access; // APB access phase awaiting answer
  logic start;  // Accepted command write

  // Next-state logic
  always_comb
  begin
    d = q;
    d.ready = 1'b0;
    d.slverr = 1'b0;
    start = 1'b0;
    access = PSEL_IN & PENABLE_IN & ~q.ready;
    // APB slave: answer one cycle into the access phase
    if (access)
    begin
      d.ready = 1'b1;
      d.rdata = 32'h0000_0000;
      case (PADDR_IN)
        OFS_CMD:
        begin
          d.rdata[WORD_BITS-1:0] = q.sh;
          // A command while busy is refused
          if (PWRITE_IN && q.st != H_IDLE)
          begin
            d.slverr = 1'b1;
          end
          else
          begin
            start = PWRITE_IN;
          end
        end
        OFS_CTRL:
        begin
          d.rdata[CTRL_STROBE] = q.strobe_n;
          d.rdata[CTRL_BYTE] = q.byte_mode;
          if (PWRITE_IN)
          begin
            d.strobe_n = PWDATA_IN[CTRL_STROBE];
            d.byte_mode = PWDATA_IN[CTRL_BYTE];
          end
        end
        OFS_STATUS:
        begin
          d.rdata[0] = (q.st != H_IDLE);
        end
        default:
        begin
          // Unmapped address
          d.slverr = 1'b1;
        end
      endcase
    end
    // Frame sequencer
    if (q.st != H_IDLE && q.tmr != 8'h00)
    begin
      d.tmr = q.tmr - 8'h01;
    end
    else
    begin
      case (q.st)
        H_IDLE:
        begin
          if (start)
          begin
            d.sh = PWDATA_IN[WORD_BITS-1:0];
            d.din = PWDATA_IN[WORD_BITS-1];
            d.sync_n = 1'b0;
            d.bits = 4'h0;
            d.tmr = HALF_LD;
            d.st = H_LEAD;
          end
        end
        H_LEAD, H_HIGH:
        begin
          d.sclk = 1'b0;
          d.tmr = HALF_LD;
          d.st = H_LOW;
        end
        H_LOW:
        begin
          d.sclk = 1'b1;
          d.bits = q.bits + 4'h1;
          d.tmr = HALF_LD;
          if (q.bits == 4'(WORD_BITS - 1))
          begin
            d.st = H_TAIL;
          end
          else
          begin
            d.sh = {q.sh[WORD_BITS-2:0], 1'b0};
            d.din = q.sh[WORD_BITS-2];
            d.st = H_HIGH;
            if (q.byte_mode && q.bits == 4'h7)
            begin
              d.tmr = PAUSE_LD;
            end
          end
        end
        H_TAIL:
        begin
          d.sync_n = 1'b1;
          d.tmr = GAP_LD;
          d.st = H_GAP;
        end
        default:
        begin
          d.st = H_IDLE;
        end
      endcase
    end
  end

  // Controller register, synchronous reset
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RESET_IN)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.sync_n <= 1'b1;
      q.sclk <= 1'b1;
      q.strobe_n <= RST_STROBE_N;
      q.byte_mode <= RST_BYTE_MODE;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the register
  assign PRDATA_OUT = q.rdata;
  assign PREADY_OUT = q.ready;
  assign PSLVERR_OUT = q.slverr;
  assign LINK.sync_n = q.sync_n;
  assign LINK.sclk = q.sclk;
  assign LINK.din = q.din;
  assign LINK.load_strobe_n = q.strobe_n;

endmodule

// File: verif/dac_load_chk.sv
// Wire-level checks on the serial link between controller and DAC
`timescale 1ns/10ps
module dac_load_chk
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic SYNC_N_IN,
  input wire logic SCLK_IN,
  input wire logic DIN_IN,
  input wire logic LOAD_STROBE_N_IN
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic sclk_q; // Link clock one core cycle back
  logic [4:0] fall_q; // Falling link edges seen in this frame

  // Count falling link edges while sync is low
  always_ff @(posedge CORE_CLK_IN)
  begin
    sclk_q <= SCLK_IN;
    if (RESET_IN || SYNC_N_IN)
      fall_q <= 5'h00;
    else if (sclk_q && !SCLK_IN)
      fall_q <= fall_q + 5'h01;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  chk_idle_high:
    assert property (SYNC_N_IN |-> SCLK_IN)
    else $error("link clock low outside a frame");
  chk_word_len:
    assert property ($rose(SYNC_N_IN) |-> fall_q == 5'h10)
    else $error("frame ended without sixteen falling edges");
  chk_din_hold:
    assert property (!SYNC_N_IN && $fell(SCLK_IN) |-> $stable(DIN_IN))
    else $error("data moved at the sampling edge");
  chk_din_launch:
    assert property (!SYNC_N_IN && !$past(SYNC_N_IN) && $changed(DIN_IN)
      |-> $rose(SCLK_IN))
    else $error("data changed away from a rising link edge");
  chk_low_phase:
    assert property ($fell(SCLK_IN) |-> (!SCLK_IN)[*4] ##1 SCLK_IN)
    else $error("link clock low phase not four cycles");
  chk_high_phase:
    assert property ($rose(SCLK_IN) |-> SCLK_IN[*4])
    else $error("link clock high phase too short");
  chk_first_fall:
    assert property ($fell(SYNC_N_IN) |-> SCLK_IN[*4] ##1 !SCLK_IN)
    else $error("first falling edge not four cycles after sync");
  chk_frame_gap:
    assert property ($rose(SYNC_N_IN) |-> SYNC_N_IN[*8] ##1 SYNC_N_IN[*2])
    else $error("sync high time between frames too short");
  chk_frame_end:
    assert property ($fell(SYNC_N_IN) |-> ##[120:200] $rose(SYNC_N_IN))
    else $error("frame did not close in time");

  // Strobe pulses are exercised
  cover property ($fell(LOAD_STROBE_N_IN));
endmodule

// File: verif/octal_dac_load_update_control_tb.sv
// Testbench joining controller and DAC ends over the serial link
`timescale 1ns/10ps
module octal_dac_load_update_control_tb
  import dac_load_pkg::*;
;
  localparam int DW = 12; // DAC code width
  localparam int LIMIT = 20000; // Cycle ceiling for the whole run
  logic core_clk, reset, link_rst; // Core clock, DAC reset, host reset
  logic psel, penable, pwrite, pready, pslverr; // APB control
  logic [11:0] paddr; // APB address
  logic [31:0] pwdata, prdata, rd; // APB data and last read
  logic err; // Last error response
  logic [CH_COUNT*DW-1:0] dac_code; // Active DAC codes
  logic [1:0] gain, buf_set, vdd_ref, load_mode; // Active settings
  logic [CH_COUNT-1:0] pwr_down; // Powered-down channels
  int bad_count, n_tests, cyc; // Counters

  // ----------------------------------------------------------------
  // Clock, ends and checker
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  dac_link_if dac_link_if_i ();

  dac_load_host dac_load_host_i
  (
    .CORE_CLK_IN(core_clk), .RESET_IN(link_rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .LINK(dac_link_if_i.host_mp)
  );

  dac_load_device #(.DATA_W(DW)) dac_load_device_i
  (
    .CORE_CLK_IN(core_clk), .RESET_IN(reset),
    .LINK(dac_link_if_i.device_mp), .DAC_CODE_OUT(dac_code),
    .GAIN_OUT(gain), .BUF_OUT(buf_set), .VDD_REF_OUT(vdd_ref),
    .POWER_DOWN_OUT(pwr_down), .LOAD_MODE_OUT(load_mode)
  );

  dac_load_chk dac_load_chk_i
  (
    .CORE_CLK_IN(core_clk), .RESET_IN(link_rst),
    .SYNC_N_IN(dac_link_if_i.sync_n), .SCLK_IN(dac_link_if_i.sclk),
    .DIN_IN(dac_link_if_i.din),
    .LOAD_STROBE_N_IN(dac_link_if_i.load_strobe_n)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Print counts and verdict, then stop
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare one value and report a difference
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let cycles pass, ending where outputs are settled
  task wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // One APB transfer; holds the request until ready is seen
  task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll busy until the frame and its gap are over
  task wait_idle;
    for (int i = 0; i < 60; i++)
    begin
      apb_xfer(1'b0, OFS_STATUS, 32'h0000_0000);
      if (rd[0] === 1'b0)
        break;
    end
    // Busy still set after the poll limit counts as a mismatch
    check(16'(rd[0]), 16'h0000);
    wait_cyc(6);
  endtask

  // Send one word over the link and wait for it to land
  task send(input logic [15:0] w);
    apb_xfer(1'b1, OFS_CMD, {16'h0000, w});
    wait_idle;
  endtask

  // Set strobe level and byte mode, then let the strobe settle
  task set_ctrl(input logic [1:0] v);
    apb_xfer(1'b1, OFS_CTRL, {30'h0000_0000, v});
    wait_cyc(8);
  endtask

  // Build a DAC write word
  function automatic logic [15:0] dw(logic [2:0] ch, logic [11:0] d);
    return {1'b0, ch, d};
  endfunction

  // Build a load-mode control word
  function automatic logic [15:0] lm(logic [1:0] m);
    return {1'b1, MODE_LOAD, 11'h000, m};
  endfunction

  // Active code of one channel
  function automatic logic [15:0] code(int ch);
    return 16'(dac_code[ch*DW +: DW]);
  endfunction

  // ----------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      summarize;
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    link_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    link_rst <= 1'b0;
    wait_cyc(2);
    check(16'(load_mode), 16'(RST_LDM));
    // Latched: input write must not reach the output
    send(dw(3'h3, 12'hA5C));
    check(code(3), 16'h0000);
    // Strobe low: pending channel loads, new writes follow
    set_ctrl(2'h0);
    check(code(3), 16'h0A5C);
    send(dw(3'h4, 12'h123));
    check(code(4), 16'h0123);
    set_ctrl(2'h1);
    send(dw(3'h4, 12'h456));
    check(code(4), 16'h0123);
    // Settings wait for a load like codes
    send({1'b1, MODE_REF_GAIN, 13'h003F});
    check(16'(gain), 16'h0000);
    set_ctrl(2'h0);
    set_ctrl(2'h1);
    check(16'({gain, buf_set, vdd_ref}), 16'h003F);
    check(code(4), 16'h0456);
    check(code(3), 16'h0A5C);
    // Single update mode loads once, then holds
    send(dw(3'h0, 12'hFFF));
    check(code(0), 16'h0000);
    send(lm(LDM_SINGLE));
    check(code(0), 16'h0FFF);
    send(dw(3'h0, 12'h001));
    check(code(0), 16'h0FFF);
    // Reserved mode keeps registers latched
    send(lm(LDM_RSVD));
    send(dw(3'h1, 12'h0AB));
    check(code(1), 16'h0000);
    // Transparent mode drains pending channels
    send(lm(LDM_LOW));
    check(code(0), 16'h0001);
    check(code(1), 16'h00AB);
    // Word sent as two bytes under one sync
    set_ctrl(2'h3);
    send(dw(3'h7, 12'h3C3));
    check(code(7), 16'h03C3);
    set_ctrl(2'h1);
    // Command while busy is refused and leaves the frame intact
    apb_xfer(1'b1, OFS_CMD, {16'h0000, dw(3'h5, 12'h555)});
    apb_xfer(1'b1, OFS_CMD, {16'h0000, dw(3'h5, 12'h0F0)});
    check(16'(err), 16'h0001);
    wait_idle;
    check(code(5), 16'h0555);
    // Unmapped address answers with an error and zero
    apb_xfer(1'b0, 12'h0FC, 32'h0000_0000);
    check(16'(err), 16'h0001);
    check(rd[15:0], 16'h0000);
    // Host reset in mid-frame cuts the word; DAC keeps its registers
    apb_xfer(1'b1, OFS_CMD, {16'h0000, dw(3'h2, 12'h777)});
    wait_cyc(40);
    @(posedge core_clk);
    link_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    link_rst <= 1'b0;
    wait_cyc(12);
    check(code(2), 16'h0000);
    send(dw(3'h2, 12'h2A2));
    check(code(2), 16'h02A2);
    // Seven inputs wait; strobe low during the eighth updates all
    send(lm(LDM_HIGH));
    for (int i = 0; i < 7; i++)
    begin
      send(dw(3'(i), 12'h800 | 12'(i)));
    end
    check(code(0), 16'h0001);
    apb_xfer(1'b1, OFS_CMD, {16'h0000, dw(3'h7, 12'h807)});
    apb_xfer(1'b1, OFS_CTRL, 32'h0000_0000);
    wait_idle;
    for (int i = 0; i < 8; i++)
    begin
      check(code(i), 16'h0800 | 16'(i));
    end
    set_ctrl(2'h1);
    // Power-down applies at once and survives a data reset
    send({1'b1, MODE_PWR_DOWN, 13'h00A5});
    check(16'(pwr_down), 16'h00A5);
    send({1'b1, MODE_RESET, 13'h0000});
    check(code(0), 16'h0000);
    check(16'({gain, buf_set, vdd_ref}), 16'h003F);
    check(16'(pwr_down), 16'h00A5);
    // Full reset clears codes, settings and power-down, and returns load mode to latched
    send({1'b1, MODE_RESET, 13'h1000});
    check(code(7), 16'h0000);
    check(16'({gain, buf_set, vdd_ref}), 16'h0000);
    check(16'(pwr_down), 16'h0000);
    check(16'(load_mode), 16'(RST_LDM));
    summarize;
  end
endmodule
